// File: hw/cfm_monitor.sv
// cfm_monitor: fault supervision of a CAN transceiver with AHB-Lite regs
// assumes line inputs synchronous to sys_clk_i; mode from mode controller
// Behaviour
// - in normal mode, four clean transmit rising edges clear bus fault
// - a bus fault never leaves the active bus state
// - six bus short cases, each counted after the filter time
// - transmit low on entering active state sets clamp, driver off
// - clamp clears at reset, clean entry, or tx high with rx low and no other local fault
// - transmit low past the dominant timeout sets flag, driver off
// - timeout flag clears on transmit rising edge or listed modes
// - receive output follows the bus during clamp or timeout
// - tx and rx shorted for the timeout sets short flag, driver off
// - short flag clears on rising edge with rx low or listed modes
// - bus dominant too long sets flag; rx rising or modes clear it
// - local faults other than heat shown on fault output only after normal to silent
// - every other mode transition clears the local fault indication
// - thermal input disables driver and shows fault while asserted
// - battery undervoltage forces the bus-off protected state
// - logic undervoltage: autonomous bus, rx high, sleep after filter
// - io undervoltage: standby, then sleep after the filter time
// - supply ready output set a recovery delay after supplies return
// - transmit idles recessive; low-power default for absent strobes
// - bus fault over four transmit rising edges sets flag, normal only
// - bus fault, latched local indication and heat are ORed onto the active-low fault output when its enable is set
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module cfm_monitor #(
  parameter int unsigned DTO_CYC    = cfm_pkg::DTO_CYC,
  parameter int unsigned BUSDOM_CYC = cfm_pkg::BUSDOM_CYC,
  parameter int unsigned UV_CYC     = cfm_pkg::UV_CYC,
  parameter int unsigned CBF_CYC    = cfm_pkg::CBF_CYC,
  parameter int unsigned RECOV_CYC  = cfm_pkg::RECOV_CYC
) (
  // clock, reset, enable
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      clk_en_i,
  // controller side lines (1 = recessive)
  input  wire logic                      tx_i,
  input  wire logic                      rx_pin_i,
  // bus receiver and detectors
  input  wire logic                      rx_bus_i,
  input  wire logic [5:0]                bus_short_i,
  input  wire logic                      thermal_i,
  input  wire logic                      uv_battery_i,
  input  wire logic                      uv_logic_i,
  input  wire logic                      uv_io_i,
  // mode controller
  input  wire cfm_pkg::cfm_mode_e        mode_i,
  // AHB-Lite slave
  input  wire logic                      hsel_i,
  input  wire logic [31:0]               haddr_i,
  input  wire logic [1:0]                htrans_i,
  input  wire logic                      hwrite_i,
  input  wire logic [2:0]                hsize_i,
  input  wire logic [31:0]               hwdata_i,
  input  wire logic                      hready_i,
  output logic [31:0]                    hrdata_o,
  output logic                           hreadyout_o,
  output logic                           hresp_o,
  // transceiver controls
  output logic                           drv_en_o,
  output logic                           rx_o,
  output logic                           fault_indicator_n_o,
  output logic                           bus_off_o,
  output logic                           autonomous_o,
  output logic                           wake_inhibit_o,
  output logic                           force_standby_o,
  output logic                           force_sleep_o,
  output logic                           supply_ready_o
);

  // ****************************************************************
  // input capture and edges
  // ****************************************************************
  logic                 tx_q;
  logic                 rx_bus_q;
  cfm_pkg::cfm_mode_e   mode_q;
  logic                 active_q;

  // edge and mode transition decode
  wire tx_rise   = tx_i && !tx_q;
  wire tx_fall   = !tx_i && tx_q;
  wire rx_rise   = rx_bus_i && !rx_bus_q;
  wire mode_chg  = mode_i != mode_q;
  wire in_normal = mode_i == cfm_pkg::CFM_NORMAL;
  wire in_silent = mode_i == cfm_pkg::CFM_SILENT;
  wire n_to_s    = mode_chg && in_silent &&
                   mode_q == cfm_pkg::CFM_NORMAL;
  wire into_clr  = mode_chg && !in_silent;
  wire other_chg = mode_chg && !n_to_s;
  wire uv_any    = uv_battery_i || uv_logic_i || uv_io_i;
  wire active    = in_normal && !uv_any;
  wire act_entry = active && !active_q;

  // tx resets recessive so an idle line never counts as dominant
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_q     <= 1'b1;
      rx_bus_q <= 1'b1;
      mode_q   <= cfm_pkg::CFM_SLEEP;
      active_q <= 1'b0;
    end else if (clk_en_i) begin
      tx_q     <= tx_i;
      rx_bus_q <= rx_bus_i;
      mode_q   <= mode_i;
      active_q <= active;
    end
  end

  // ****************************************************************
  // dwell timers
  // ****************************************************************
  logic dto_hit;
  logic short_hit;
  logic dom_hit;
  logic uvl_hit;
  logic uvi_hit;
  logic recov_hit;
  logic [5:0] cbf_hit;

  // tx low restarts on each falling edge, counted in the active state
  cfm_timer u_dto (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .run_i     (!tx_i && !tx_fall && active),
    .limit_i   (cfm_pkg::CNT_W'(DTO_CYC)),
    .hit_o     (dto_hit)
  );

  // pins tied: rx pin follows tx instead of what we drive
  wire short_cond = (rx_pin_i == tx_i) && (rx_pin_i != rx_o);
  cfm_timer u_short (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .run_i     (short_cond),
    .limit_i   (cfm_pkg::CNT_W'(DTO_CYC)),
    .hit_o     (short_hit)
  );

  cfm_timer u_dom (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .run_i     (!rx_bus_i),
    .limit_i   (cfm_pkg::CNT_W'(BUSDOM_CYC)),
    .hit_o     (dom_hit)
  );

  cfm_timer u_uvl (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .run_i     (uv_logic_i),
    .limit_i   (cfm_pkg::CNT_W'(UV_CYC)),
    .hit_o     (uvl_hit)
  );

  cfm_timer u_uvi (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .run_i     (uv_io_i),
    .limit_i   (cfm_pkg::CNT_W'(UV_CYC)),
    .hit_o     (uvi_hit)
  );

  // recovery waits for all supplies valid for the whole delay
  cfm_timer u_recov (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .run_i     (!uv_any),
    .limit_i   (cfm_pkg::CNT_W'(RECOV_CYC)),
    .hit_o     (recov_hit)
  );

  // one filter per short case, only judged while sending dominant
  for (genvar i = 0; i < cfm_pkg::CBF_CASES; i++) begin : g_cbf
    cfm_timer u_cbf (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .clk_en_i  (clk_en_i),
      .run_i     (bus_short_i[i] && !tx_i && drv_en_o),
      .limit_i   (cfm_pkg::CNT_W'(CBF_CYC)),
      .hit_o     (cbf_hit[i])
    );
  end

  // ****************************************************************
  // bus fault edge runs
  // ****************************************************************
  logic cbf_seen;
  logic cbf_set;
  logic cbf_clr;

  // remember a filtered fault within the current dominant bit
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cbf_seen <= 1'b0;
    end else if (clk_en_i) begin
      if (|cbf_hit) cbf_seen <= 1'b1;
      else if (tx_rise) cbf_seen <= 1'b0;
    end
  end

  wire cbf_now = cbf_seen || (|cbf_hit);

  cfm_run_cnt u_run_bad (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .clr_i     (!in_normal),
    .step_i    (tx_rise && in_normal),
    .qual_i    (cbf_now),
    .done_o    (cbf_set)
  );

  cfm_run_cnt u_run_good (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .clr_i     (!in_normal),
    .step_i    (tx_rise && in_normal),
    .qual_i    (!cbf_now),
    .done_o    (cbf_clr)
  );

  // ****************************************************************
  // fault flags
  // ****************************************************************
  cfm_pkg::cfm_flags_s flags;
  cfm_pkg::cfm_flags_s next_flags;

  wire other_local = flags.tx_dominant_timeout_flag ||
                     flags.tx_rx_short_flag ||
                     flags.bus_stuck_dominant_flag ||
                     flags.thermal_shutdown_flag;
  wire any_local   = other_local || flags.tx_clamped_flag;

  // set wins over clear on every hardware-set flag
  always_comb begin
    next_flags = flags;
    // bus fault: normal mode only, leaving normal drops it
    if (cbf_set) next_flags.bus_fault_flag = 1'b1;
    else if (cbf_clr || !in_normal)
      next_flags.bus_fault_flag = 1'b0;
    // clamp decided on entry to the active state
    if (act_entry && !tx_i) next_flags.tx_clamped_flag = 1'b1;
    else if (act_entry ||
             (tx_i && !rx_bus_i && !other_local))
      next_flags.tx_clamped_flag = 1'b0;
    if (dto_hit) next_flags.tx_dominant_timeout_flag = 1'b1;
    else if (tx_rise || into_clr)
      next_flags.tx_dominant_timeout_flag = 1'b0;
    if (short_hit) next_flags.tx_rx_short_flag = 1'b1;
    else if ((tx_rise && !rx_pin_i) || into_clr)
      next_flags.tx_rx_short_flag = 1'b0;
    if (dom_hit) next_flags.bus_stuck_dominant_flag = 1'b1;
    else if (rx_rise || into_clr)
      next_flags.bus_stuck_dominant_flag = 1'b0;
    // heat follows the detector level directly
    next_flags.thermal_shutdown_flag = thermal_i;
    // indication latched only on the normal to silent step
    if (n_to_s && any_local) next_flags.local_ind = 1'b1;
    else if (other_chg) next_flags.local_ind = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) flags <= '0;
    else if (clk_en_i) flags <= next_flags;
  end

  // ****************************************************************
  // register interface
  // ****************************************************************
  logic [1:0]  ctrl;
  logic        wr_pend;
  logic [7:0]  wr_addr;

  wire ahb_go  = hsel_i && hready_i && htrans_i[1];
  wire hit_hi  = haddr_i[31:8] == 24'h000000;
  wire [7:0] a = haddr_i[7:0];
  wire [31:0] rd_ctrl   = {30'h0, ctrl};
  wire [31:0] rd_status = {25'h0, flags};
  wire [31:0] rd_supply = {23'h0, supply_ready_o, force_sleep_o,
                           force_standby_o, autonomous_o, bus_off_o,
                           1'b0, mode_q};

  // read decode; unmapped words read zero
  wire [31:0] rd_val =
    !hit_hi               ? 32'h0 :
    (a == cfm_pkg::REG_CTRL)   ? rd_ctrl :
    (a == cfm_pkg::REG_STATUS) ? rd_status :
    (a == cfm_pkg::REG_SUPPLY) ? rd_supply : 32'h0;

  // zero-wait slave: read data latched in the address phase
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h0;
    end else if (clk_en_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend     <= ahb_go && hwrite_i && hit_hi;
      wr_addr     <= a;
      if (ahb_go && !hwrite_i) hrdata_o <= rd_val;
    end
  end

  // control write in the data phase; other offsets ignore writes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) ctrl <= cfm_pkg::CTRL_RST;
    else if (clk_en_i && wr_pend && wr_addr == cfm_pkg::REG_CTRL)
      ctrl <= hwdata_i[1:0];
  end

  // ****************************************************************
  // transceiver outputs
  // ****************************************************************
  // bus faults stay out of this term so the node keeps talking
  wire mode_drv = active && ctrl[cfm_pkg::CTRL_DRV];
  wire next_drv = mode_drv &&
                  !flags.tx_clamped_flag &&
                  !flags.tx_dominant_timeout_flag &&
                  !flags.tx_rx_short_flag &&
                  !thermal_i;

  // receiver keeps mirroring the bus through local faults
  wire next_rx = uv_logic_i ? 1'b1 :
                 (in_normal || in_silent) ? rx_bus_i :
                 1'b1;

  wire next_flt = (flags.bus_fault_flag && in_normal) ||
                  flags.local_ind || thermal_i;

  // sleep demanded once either filtered undervoltage has lasted
  wire next_sleep = uvl_hit || uvi_hit;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      drv_en_o            <= 1'b0;
      rx_o                <= 1'b1;
      fault_indicator_n_o <= 1'b1;
      bus_off_o           <= 1'b0;
      autonomous_o        <= 1'b0;
      wake_inhibit_o      <= 1'b0;
      force_standby_o     <= 1'b0;
      force_sleep_o       <= 1'b0;
      supply_ready_o      <= 1'b0;
    end else if (clk_en_i) begin
      drv_en_o            <= next_drv && !uv_any;
      rx_o                <= next_rx;
      fault_indicator_n_o <= !(next_flt &&
                               ctrl[cfm_pkg::CTRL_FLT]);
      bus_off_o           <= uv_battery_i;
      autonomous_o        <= uv_logic_i;
      wake_inhibit_o      <= uv_logic_i;
      force_standby_o     <= uv_io_i;
      if (next_sleep) force_sleep_o <= 1'b1;
      else if (!uv_logic_i && !uv_io_i) force_sleep_o <= 1'b0;
      supply_ready_o      <= recov_hit;
    end
  end

endmodule : cfm_monitor

// File: hw/cfm_pkg.sv
// ****************************************************************
// cfm_pkg: constants, modes, register map and flag layout of the
// transceiver fault monitor
// ****************************************************************
// assumes a 250 MHz system clock; all counts derive from it
package cfm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam real CLK_PERIOD_NS = 4.0;
  localparam int  CNT_W         = 24;
  // dominant timeout, least time, so the count rounds up
  localparam real DTO_TIME_MS   = 1.2;
  localparam int  DTO_CYC       =
    int'($ceil(DTO_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  // bus dominant, undervoltage and bus fault filters: plain defaults
  localparam real BUSDOM_TIME_US = 4000.0;
  localparam int  BUSDOM_CYC     =
    int'($ceil(BUSDOM_TIME_US * 1.0e3 / CLK_PERIOD_NS));
  localparam real UV_TIME_US    = 1000.0;
  localparam int  UV_CYC        =
    int'($ceil(UV_TIME_US * 1.0e3 / CLK_PERIOD_NS));
  localparam real CBF_TIME_US   = 1.0;
  localparam int  CBF_CYC       =
    int'($ceil(CBF_TIME_US * 1.0e3 / CLK_PERIOD_NS));
  // supply recovery delay, typical figure
  localparam real RECOV_TIME_US = 200.0;
  localparam int  RECOV_CYC     =
    int'($ceil(RECOV_TIME_US * 1.0e3 / CLK_PERIOD_NS));

  // ****************************************************************
  // fault counting
  // ****************************************************************
  localparam int       RUN_W      = 3;
  localparam logic [2:0] RUN_LEN  = 3'h4;
  localparam int       CBF_CASES  = 6;

  // ****************************************************************
  // operating modes from the mode controller
  // ****************************************************************
  typedef enum logic [2:0] {
    CFM_NORMAL  = 3'b000,
    CFM_SILENT  = 3'b001,
    CFM_STANDBY = 3'b010,
    CFM_GOSLEEP = 3'b011,
    CFM_SLEEP   = 3'b100
  } cfm_mode_e;

  // ****************************************************************
  // register map (byte addresses) and reset values
  // ****************************************************************
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_SUPPLY = 8'h08;
  localparam logic [1:0]  CTRL_RST   = 2'h3;
  localparam int          CTRL_DRV   = 0;
  localparam int          CTRL_FLT   = 1;

  // flag set, also the layout of the status register
  typedef struct packed {
    logic bus_fault_flag;
    logic tx_clamped_flag;
    logic tx_dominant_timeout_flag;
    logic tx_rx_short_flag;
    logic bus_stuck_dominant_flag;
    logic thermal_shutdown_flag;
    logic local_ind;
  } cfm_flags_s;

endpackage : cfm_pkg

// File: hw/cfm_timer.sv
// cfm_timer: dwell timer, reports once a condition has held long enough
// assumes run is synchronous to sys_clk_i
`timescale 1ns/1ps
module cfm_timer (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      clk_en_i,
  // condition and threshold
  input  wire logic                      run_i,
  input  wire logic [cfm_pkg::CNT_W-1:0] limit_i,
  output logic                           hit_o
);
  logic [cfm_pkg::CNT_W-1:0] cnt;

  // count while run holds, restart when it drops; saturates at limit
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt <= '0;
    end else if (clk_en_i) begin
      if (!run_i) cnt <= '0;
      else if (cnt != limit_i) cnt <= cnt + 1'b1;
    end
  end

  assign hit_o = run_i && (cnt == limit_i);
endmodule : cfm_timer

// File: hw/cfm_run_cnt.sv
// cfm_run_cnt: counts consecutive qualified transmit edges
// assumes step_i is a one-cycle pulse per edge
`timescale 1ns/1ps
module cfm_run_cnt (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic clk_en_i,
  // events
  input  wire logic clr_i,
  input  wire logic step_i,
  input  wire logic qual_i,
  output logic      done_o
);
  logic [cfm_pkg::RUN_W-1:0] cnt;

  // an unqualified edge breaks the run
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt <= '0;
    end else if (clk_en_i) begin
      if (clr_i) cnt <= '0;
      else if (step_i && !qual_i) cnt <= '0;
      else if (step_i && cnt != cfm_pkg::RUN_LEN) cnt <= cnt + 1'b1;
    end
  end

  assign done_o = step_i && qual_i &&
                  (cnt == cfm_pkg::RUN_LEN - 3'h1);
endmodule : cfm_run_cnt

// File: dv/cfm_monitor_sva.sv
// cfm_monitor_sva: port timing checks of the fault monitor
// assumes clk_en_i held high and the fault output enable left set
`timescale 1ns/1ps
module cfm_monitor_sva #(
  parameter int unsigned DTO_CYC = 50
) (
  // clock and reset
  input wire logic               sys_clk_i,
  input wire logic               srst_i,
  // watched inputs
  input wire logic               tx_i, thermal_i,
  input wire logic               uv_battery_i, uv_logic_i, uv_io_i,
  input wire cfm_pkg::cfm_mode_e mode_i,
  // watched outputs
  input wire logic               hreadyout_o, hresp_o, drv_en_o, rx_o,
  input wire logic               fault_indicator_n_o, bus_off_o,
  input wire logic               autonomous_o, wake_inhibit_o,
  input wire logic               force_standby_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // ****
  // helpers
  // ****
  int unsigned low_cnt;
  // dominant run length, saturating so a stuck line never wraps it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || tx_i) low_cnt <= 0;
    else if (low_cnt < DTO_CYC + 8) low_cnt <= low_cnt + 1;
  end
  sequence hot_s; thermal_i [*3]; endsequence
  sequence off_mode_s; (mode_i != cfm_pkg::CFM_NORMAL) [*3]; endsequence
  sequence after_rst_s; $fell(srst_i) ##1 hreadyout_o; endsequence

  // ****
  // properties
  // ****
  bus_ready_a: assert property (after_rst_s |-> ##1 hreadyout_o)
    else $error("bus slave not ready after reset");
  bus_okay_a: assert property (hreadyout_o |-> !hresp_o)
    else $error("bus response not okay");
  hot_drv_a: assert property (hot_s |-> !drv_en_o)
    else $error("driver on while hot");
  hot_flag_a: assert property (hot_s |-> !fault_indicator_n_o)
    else $error("heat not shown on fault output");
  mode_drv_a: assert property (off_mode_s |-> !drv_en_o)
    else $error("driver on outside normal mode");
  dto_drv_a: assert property (low_cnt == DTO_CYC + 6 |-> !drv_en_o)
    else $error("driver on past dominant timeout");
  bat_off_a: assert property (uv_battery_i [*3] |-> bus_off_o && !drv_en_o)
    else $error("no bus off on battery undervoltage");
  logic_uv_a: assert property (uv_logic_i [*3] |->
    autonomous_o && wake_inhibit_o && rx_o)
    else $error("logic undervoltage state wrong");
  io_uv_a: assert property (uv_io_i [*3] |-> force_standby_o)
    else $error("no standby on io undervoltage");
endmodule : cfm_monitor_sva

bind cfm_monitor cfm_monitor_sva #(.DTO_CYC(DTO_CYC)) u_cfm_monitor_sva (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .tx_i(tx_i),
  .thermal_i(thermal_i), .uv_battery_i(uv_battery_i),
  .uv_logic_i(uv_logic_i), .uv_io_i(uv_io_i), .mode_i(mode_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .drv_en_o(drv_en_o),
  .rx_o(rx_o), .fault_indicator_n_o(fault_indicator_n_o),
  .bus_off_o(bus_off_o), .autonomous_o(autonomous_o),
  .wake_inhibit_o(wake_inhibit_o), .force_standby_o(force_standby_o));

// File: dv/cfm_ctrl_model.sv
// cfm_ctrl_model: protocol controller stand-in driving transmit
// assumes go_i is a one-cycle pulse given while busy_o is low
`timescale 1ns/1ps
module cfm_ctrl_model #(
  parameter int LEN = 10
) (
  // clock
  input  wire logic       sys_clk_i,
  // commands
  input  wire logic       go_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] bits_i,
  // transmit line
  output logic            tx_o,
  output logic            busy_o
);
  int   cnt = 0;
  logic dom;
  initial tx_o = 1'b1;
  // each bit: LEN dominant cycles, then LEN recessive cycles
  assign dom = (cnt != 0) && (((cnt - 1) / LEN) % 2 == 1);
  assign busy_o = (cnt != 0);
  // pushed hard both ways, never left to a weak pull-up
  always @(posedge sys_clk_i) begin
    if (go_i && cnt == 0) cnt <= 2 * LEN * bits_i;
    else if (cnt != 0) cnt <= cnt - 1;
    tx_o <= !(hold_i || dom);
  end
endmodule : cfm_ctrl_model

// File: dv/test_cfm_monitor.sv
// test_cfm_monitor: directed tests of the fault monitor
// assumes cfm_pkg, the checker and the controller model compiled first
`timescale 1ns/1ps
module test_cfm_monitor;
  localparam int DTO = 50, BDOM = 80, UVC = 30, RECV = 20;
  logic        sys_clk = 1'b0, srst = 1'b1;
  logic        go = 1'b0, hold = 1'b0, stuck = 1'b0, rx_bus = 1'b1;
  logic        therm = 1'b0, uvb = 1'b0, uvl = 1'b0, uvi = 1'b0;
  logic [5:0]  bshort = 6'h00;
  logic        txrx = 1'b0; // ties the rx pin onto tx to fake a pin short
  logic [3:0]  nbits = 4'h4;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata;
  logic        tx, busy, hrdy, hresp, drv, rxo, fltn, boff, auton, wkinh;
  logic        fstb, fslp, srdy;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  cfm_pkg::cfm_mode_e mode = cfm_pkg::CFM_NORMAL;

  always #2 sys_clk = ~sys_clk;
  // bus is dominant only while our driver pulls it or a fault holds it
  always @(posedge sys_clk) rx_bus <= ~stuck & (tx | ~drv);

  cfm_monitor #(.DTO_CYC(DTO), .BUSDOM_CYC(BDOM), .UV_CYC(UVC),
    .CBF_CYC(4), .RECOV_CYC(RECV)) u_cfm_monitor (
    .sys_clk_i(sys_clk), .srst_i(srst), .clk_en_i(1'b1), .tx_i(tx),
    .rx_pin_i(txrx ? tx : rxo), .rx_bus_i(rx_bus),
    .bus_short_i(bshort),
    .thermal_i(therm), .uv_battery_i(uvb), .uv_logic_i(uvl),
    .uv_io_i(uvi), .mode_i(mode), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .drv_en_o(drv), .rx_o(rxo),
    .fault_indicator_n_o(fltn), .bus_off_o(boff), .autonomous_o(auton),
    .wake_inhibit_o(wkinh), .force_standby_o(fstb),
    .force_sleep_o(fslp), .supply_ready_o(srdy));

  cfm_ctrl_model u_cfm_ctrl_model (.sys_clk_i(sys_clk), .go_i(go),
    .hold_i(hold), .bits_i(nbits), .tx_o(tx), .busy_o(busy));

  // ****
  // tasks
  // ****
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // single transfer; each phase held until the slave reports ready
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
    do @(posedge sys_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : xfer
  task rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task burst(input logic [3:0] n);
    nbits <= n; go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(2);
    while (busy) cyc(1);
    cyc(3);
  endtask : burst
  task results();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // hang guard, far above the roughly 1400 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    cyc(4);
    chk({drv, fltn, hrdy}, 32'h2);
    srst <= 1'b0;
    cyc(8);
    rd(32'h0, 32'h3);
    rd(32'h40, 32'h0);
    xfer(1'b1, 32'h4, 32'h7f);
    rd(32'h4, 32'h0);
    xfer(1'b1, 32'h0, 32'h2);
    cyc(4);
    chk(drv, 32'h0);
    xfer(1'b1, 32'h0, 32'h3);
    cyc(4);
    chk(drv, 32'h1);
    $display("register test done");
    for (int k = 0; k < 6; k++) begin
      bshort <= 6'h01 << k;
      burst(4'h4);
      chk({drv, fltn}, 32'h2);
      rd(32'h4, 32'h40);
      bshort <= 6'h00;
      burst(4'h4);
      chk(fltn, 32'h1);
    end
    $display("bus fault test done");
    hold <= 1'b1;
    cyc(DTO + 8);
    chk({drv, rxo}, 32'h1);
    rd(32'h4, 32'h10);
    hold <= 1'b0;
    cyc(5);
    chk(drv, 32'h1);
    rd(32'h4, 32'h0);
    therm <= 1'b1;
    cyc(5);
    chk({drv, fltn}, 32'h0);
    therm <= 1'b0;
    cyc(5);
    chk({drv, fltn}, 32'h3);
    $display("driver fault test done");
    stuck <= 1'b1;
    cyc(BDOM + 6);
    rd(32'h4, 32'h4);
    chk(fltn, 32'h1);
    mode <= cfm_pkg::CFM_SILENT;
    cyc(5);
    chk(fltn, 32'h0);
    stuck <= 1'b0; mode <= cfm_pkg::CFM_STANDBY;
    cyc(5);
    chk(fltn, 32'h1);
    rd(32'h4, 32'h0);
    hold <= 1'b1;
    cyc(2);
    mode <= cfm_pkg::CFM_NORMAL;
    cyc(5);
    chk(drv, 32'h0);
    rd(32'h4, 32'h20);
    hold <= 1'b0; stuck <= 1'b1;
    cyc(4);
    stuck <= 1'b0;
    cyc(5);
    chk(drv, 32'h1);
    rd(32'h4, 32'h0);
    txrx <= 1'b1;
    stuck <= 1'b1;
    cyc(DTO + 6);
    chk(drv, 32'h0);
    rd(32'h4, 32'h8);
    txrx <= 1'b0;
    hold <= 1'b1;
    cyc(2);
    hold <= 1'b0;
    cyc(5);
    chk(drv, 32'h1);
    stuck <= 1'b0;
    rd(32'h4, 32'h0);
    $display("local fault test done");
    stuck <= 1'b1; uvl <= 1'b1;
    cyc(5);
    chk({auton, wkinh, rxo}, 32'h7);
    cyc(UVC + 4);
    chk(fslp, 32'h1);
    stuck <= 1'b0; uvl <= 1'b0; uvi <= 1'b1;
    cyc(5);
    chk(fstb, 32'h1);
    uvi <= 1'b0;
    cyc(5);
    chk(srdy, 32'h0);
    cyc(RECV + 6);
    chk(srdy, 32'h1);
    uvb <= 1'b1;
    cyc(5);
    chk({boff, drv}, 32'h2);
    uvb <= 1'b0;
    $display("supply test done");
    results();
  end
endmodule : test_cfm_monitor
